// File: common/mopm_pkg.sv
/*
 * Package for the metering output pin multiplexer: register map, field
 * positions, reset values, mode codes and timing counts.
 * Assumes an APB slave with 32-bit data and word-aligned registers.
 */
// Operation
// - modes 2 and 3 drive the motor pins with stepper phases b and a
// - mode 0 puts watchdog on motor_out_b and zero-cross on motor_out_a
// - mode 1 puts current and voltage bitstreams on the motor pins
// - mode 2 LED gives fast active-energy pulses at half duty
// - mode 3 LED gives active-energy pulse; constant picked by select bit
// - mode 0 LED gives active, reactive or apparent pulse per select
// - mode 1 LED shows tamper channel select: low primary, high secondary
// - stand-alone no-load pin is low while no-load is detected
// - stand-alone tamper pin low on tamper; peripheral mode leaves it to SPI
// - stand-alone negative power pin low while negative power seen
// - indications shown only while indicator enable input is high
// - one positive zero-cross pulse for each line voltage zero crossing
// - slope sign high while voltage rises, low while it falls
// - range fault sets out of band or below 64; clears in band above 128
// - tamper flag high on tamper, seen in status and stand-alone pin
// - no-load flag one on no-load, seen in status and stand-alone pin
// - three pulse trains proportional to active, reactive, apparent energy
package mopm_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
	localparam logic [7:0] OFS_IRQ_EN = 8'h0C;
	localparam logic [7:0] OFS_IRQ_CLR = 8'h10;
	localparam logic [7:0] OFS_ENERGY = 8'h14;
	localparam logic [7:0] OFS_VOLTAGE = 8'h18;
	localparam logic [7:0] OFS_SIDE = 8'h1C;
	// control field positions
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_KSEL_BIT = 2;
	localparam int CTRL_KLED_LSB = 3;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	// side-info register bits: frequency in band, tamper channel, watchdog, tamper, no-load, negative power
	localparam int SIDE_INBAND = 0;
	localparam int SIDE_CHSEL = 1;
	localparam int SIDE_WDOG = 2;
	localparam int SIDE_TAMPER = 3;
	localparam int SIDE_NOLOAD = 4;
	localparam int SIDE_NEG = 5;
	// status / interrupt bit positions
	localparam int ST_TAMPER = 0;
	localparam int ST_NOLOAD = 1;
	localparam int ST_RANGE = 2;
	localparam int ST_NEG = 3;
	localparam int ST_ZCROSS = 4;
	localparam int NUM_EV = 5;
	// voltage thresholds for the range fault
	localparam logic [15:0] V_LOW_LIMIT = 16'h0040;
	localparam logic [15:0] V_HIGH_LIMIT = 16'h0080;
	// energy accumulators and pulse widths
	localparam int ACC_W = 24;
	localparam logic [ACC_W-1:0] K_LOW = 24'h010000;
	localparam logic [ACC_W-1:0] K_HIGH = 24'h004000;
	localparam logic [ACC_W-1:0] K_FAST = 24'h000400;
	localparam int PULSE_NS = 100;
	localparam int CLK_MHZ = 100;
	localparam int PULSE_CYC = (PULSE_NS * CLK_MHZ + 999) / 1000;
	typedef enum logic [1:0] {
		MODE_PERIPH_WD = 2'b00,
		MODE_PERIPH_DS = 2'b01,
		MODE_STAND_FAST = 2'b10,
		MODE_STAND_CNT = 2'b11
	} mopm_mode_t;
	typedef enum logic [1:0] {
		KLED_ACTIVE = 2'b00,
		KLED_REACTIVE = 2'b01,
		KLED_APPARENT = 2'b10
	} mopm_kled_t;
endpackage

// File: logic/mopm_top.sv
/*
 * Metering output pin multiplexer: energy pulse trains, zero-cross and
 * slope detection, range fault, indicator flags, APB registers, interrupt.
 * Assumes signed voltage samples and per-cycle signed power increments
 * from the DSP, all synchronous to CLOCK; stepper phases come from a
 * motor driver elsewhere.
 */
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/10ps
module mopm_top (
	input wire logic CLOCK,
	input wire logic SYS_RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic [15:0] VOLT_SAMPLE,
	input wire logic VOLT_VALID,
	input wire logic [15:0] ACT_POWER,
	input wire logic [15:0] REACT_POWER,
	input wire logic [15:0] APP_POWER,
	input wire logic CUR_BITSTREAM,
	input wire logic VOLT_BITSTREAM,
	input wire logic STEPPER_PHASE_A,
	input wire logic STEPPER_PHASE_B,
	input wire logic INDICATOR_ENABLE_SELECT,
	input wire logic SPI_DATA_OUT,
	input wire logic SPI_DATA_OE,
	output logic MOTOR_OUT_A,
	output logic MOTOR_OUT_B,
	output logic LED,
	output logic NO_LOAD_PIN,
	output logic NO_LOAD_PIN_OE,
	output logic TAMPER_PIN,
	output logic TAMPER_PIN_OE,
	output logic NEGATIVE_POWER_INDICATOR,
	output logic NEGATIVE_POWER_INDICATOR_OE,
	output logic IRQ
);
	localparam int NUM_EV_W = mopm_pkg::NUM_EV;

	typedef struct packed {
		logic [31:0] ctrl;
		logic [5:0] side;
		logic [NUM_EV_W-1:0] ist;
		logic [NUM_EV_W-1:0] ien;
		logic [31:0] prdata;
		logic [2:0][mopm_pkg::ACC_W-1:0] acc;
		logic [2:0] epulse;
		logic [2:0][3:0] ewid;
		logic [mopm_pkg::ACC_W-1:0] facc;
		logic fled;
		logic [15:0] vprev;
		logic slope;
		logic zc;
		logic vsign;
		logic fault;
		logic mo_a;
		logic mo_b;
		logic led;
		logic nl;
		logic nl_oe;
		logic td;
		logic td_oe;
		logic ng;
		logic ng_oe;
		logic [NUM_EV_W-1:0] prev_lvl;
	} mopm_state_t;

	mopm_state_t s_r;
	mopm_state_t s_nxt;

	// constant for one channel, chosen by select bit (low count = high rate)
	function automatic logic [mopm_pkg::ACC_W-1:0] pulse_const(
		input logic ksel
	);
		pulse_const = ksel ? mopm_pkg::K_HIGH : mopm_pkg::K_LOW;
	endfunction

	// magnitude of a signed 16-bit power sample, widened to accumulator
	function automatic logic [mopm_pkg::ACC_W-1:0] mag(input logic [15:0] p);
		logic [15:0] m;
		m = p[15] ? 16'(-p) : p;
		mag = {8'h00, m};
	endfunction

	logic apb_wr;
	logic apb_rd;
	logic [1:0] mode;
	logic ksel;
	logic [1:0] kled;
	logic stand;
	logic tamper;
	logic noload;
	logic neg;
	logic inband;
	logic [NUM_EV_W-1:0] lvl;
	logic [NUM_EV_W-1:0] rise;
	logic [2:0][15:0] pw;

	// zero wait-state slave: access completes in its first access cycle
	assign PREADY = 1'b1;
	assign PSLVERR = 1'b0;
	assign apb_wr = PSEL & PENABLE & PWRITE;
	assign apb_rd = PSEL & ~PENABLE & ~PWRITE;

	assign mode = s_r.ctrl[mopm_pkg::CTRL_MODE_LSB +: 2];
	assign ksel = s_r.ctrl[mopm_pkg::CTRL_KSEL_BIT];
	assign kled = s_r.ctrl[mopm_pkg::CTRL_KLED_LSB +: 2];
	assign stand = mode[1];
	assign inband = s_r.side[mopm_pkg::SIDE_INBAND];
	assign tamper = s_r.side[mopm_pkg::SIDE_TAMPER];
	assign noload = s_r.side[mopm_pkg::SIDE_NOLOAD];
	assign neg = s_r.side[mopm_pkg::SIDE_NEG];
	assign pw[0] = ACT_POWER;
	assign pw[1] = REACT_POWER;
	assign pw[2] = APP_POWER;

	// level events feeding the sticky status; zero cross is a pulse
	always_comb
	begin
		lvl = '0;
		lvl[mopm_pkg::ST_TAMPER] = tamper;
		lvl[mopm_pkg::ST_NOLOAD] = noload;
		lvl[mopm_pkg::ST_RANGE] = s_r.fault;
		lvl[mopm_pkg::ST_NEG] = neg;
		lvl[mopm_pkg::ST_ZCROSS] = s_r.zc;
		rise = lvl & ~s_r.prev_lvl;
	end

	// next-state logic for the whole block
	always_comb
	begin
		logic [mopm_pkg::ACC_W-1:0] sum;
		logic [mopm_pkg::ACC_W-1:0] k;
		logic [mopm_pkg::ACC_W-1:0] fsum;
		logic vs;
		logic e_sel;
		sum = '0;
		k = '0;
		fsum = '0;
		vs = 1'b0;
		e_sel = 1'b0;
		s_nxt = s_r;
		s_nxt.prev_lvl = lvl;

		// register writes
		if (apb_wr)
		begin
			case (PADDR)
				mopm_pkg::OFS_CTRL: s_nxt.ctrl = {27'h0, PWDATA[4:0]};
				mopm_pkg::OFS_IRQ_EN: s_nxt.ien = PWDATA[NUM_EV_W-1:0];
				mopm_pkg::OFS_SIDE: s_nxt.side = PWDATA[5:0];
				default: ;
			endcase
		end

		// sticky events; a new event wins over a clear in the same cycle
		if (apb_wr && PADDR == mopm_pkg::OFS_IRQ_CLR)
			s_nxt.ist = s_r.ist & ~PWDATA[NUM_EV_W-1:0];
		s_nxt.ist = s_nxt.ist | rise;

		// read data captured in setup so it is stable in the access phase
		if (apb_rd)
		begin
			case (PADDR)
				mopm_pkg::OFS_CTRL: s_nxt.prdata = s_r.ctrl;
				mopm_pkg::OFS_STATUS: s_nxt.prdata = {27'h0, lvl};
				mopm_pkg::OFS_IRQ_STAT: s_nxt.prdata = {27'h0, s_r.ist};
				mopm_pkg::OFS_IRQ_EN: s_nxt.prdata = {27'h0, s_r.ien};
				mopm_pkg::OFS_ENERGY:
					s_nxt.prdata = {29'h0, s_r.epulse};
				mopm_pkg::OFS_VOLTAGE:
					s_nxt.prdata = {15'h0, s_r.slope, s_r.vprev};
				mopm_pkg::OFS_SIDE: s_nxt.prdata = {26'h0, s_r.side};
				default: s_nxt.prdata = 32'h0000_0000;
			endcase
		end

		// three energy pulse trains; each overflow gives a fixed-width pulse
		k = pulse_const(ksel);
		for (int i = 0; i < 3; i++)
		begin
			sum = s_r.acc[i] + mag(pw[i]);
			if (s_r.ewid[i] != 4'h0)
				s_nxt.ewid[i] = s_r.ewid[i] - 4'h1;
			if (sum >= k)
			begin
				s_nxt.acc[i] = sum - k;
				s_nxt.ewid[i] = 4'(mopm_pkg::PULSE_CYC);
			end
			else
				s_nxt.acc[i] = sum;
			s_nxt.epulse[i] = (s_nxt.ewid[i] != 4'h0);
		end

		// fast LED: toggles per half quantum, so duty is exactly half
		fsum = s_r.facc + mag(pw[0]);
		if (fsum >= (mopm_pkg::K_FAST >> 1))
		begin
			s_nxt.facc = fsum - (mopm_pkg::K_FAST >> 1);
			s_nxt.fled = ~s_r.fled;
		end
		else
			s_nxt.facc = fsum;

		// voltage slope, zero crossing and range fault
		s_nxt.zc = 1'b0;
		if (VOLT_VALID)
		begin
			s_nxt.vprev = VOLT_SAMPLE;
			if ($signed(VOLT_SAMPLE) > $signed(s_r.vprev))
				s_nxt.slope = 1'b1;
			else if ($signed(VOLT_SAMPLE) < $signed(s_r.vprev))
				s_nxt.slope = 1'b0;
			vs = VOLT_SAMPLE[15];
			s_nxt.vsign = vs;
			s_nxt.zc = (vs != s_r.vsign);
			// hysteresis on magnitude between the two limits
			if (!inband || mag(VOLT_SAMPLE) < {8'h00, mopm_pkg::V_LOW_LIMIT})
				s_nxt.fault = 1'b1;
			else if (mag(VOLT_SAMPLE) > {8'h00, mopm_pkg::V_HIGH_LIMIT})
				s_nxt.fault = 1'b0;
		end
		else if (!inband)
			s_nxt.fault = 1'b1;

		// motor pins; registered so a mode write cannot glitch them
		case (mopm_pkg::mopm_mode_t'(mode))
			mopm_pkg::MODE_PERIPH_WD:
			begin
				s_nxt.mo_b = s_r.side[mopm_pkg::SIDE_WDOG];
				s_nxt.mo_a = s_r.zc;
			end
			mopm_pkg::MODE_PERIPH_DS:
			begin
				s_nxt.mo_b = CUR_BITSTREAM;
				s_nxt.mo_a = VOLT_BITSTREAM;
			end
			default:
			begin
				s_nxt.mo_b = STEPPER_PHASE_B;
				s_nxt.mo_a = STEPPER_PHASE_A;
			end
		endcase

		// LED source per mode
		case (kled)
			2'b01: e_sel = s_r.epulse[1];
			2'b10: e_sel = s_r.epulse[2];
			default: e_sel = s_r.epulse[0];
		endcase
		case (mopm_pkg::mopm_mode_t'(mode))
			mopm_pkg::MODE_PERIPH_WD: s_nxt.led = e_sel;
			mopm_pkg::MODE_PERIPH_DS:
				s_nxt.led = s_r.side[mopm_pkg::SIDE_CHSEL];
			mopm_pkg::MODE_STAND_FAST: s_nxt.led = s_r.fled;
			default: s_nxt.led = s_r.epulse[0];
		endcase

		// indicator pins: driven low-active only in stand-alone with enable
		s_nxt.nl_oe = stand && INDICATOR_ENABLE_SELECT;
		s_nxt.nl = ~noload;
		s_nxt.ng_oe = stand && INDICATOR_ENABLE_SELECT;
		s_nxt.ng = ~neg;
		if (stand)
		begin
			s_nxt.td_oe = INDICATOR_ENABLE_SELECT;
			s_nxt.td = ~tamper;
		end
		else
		begin
			// peripheral mode hands the pin to the serial port
			s_nxt.td_oe = SPI_DATA_OE;
			s_nxt.td = SPI_DATA_OUT;
		end
	end

	// one state register; pins and read data leave from flops, except IRQ (gated from them) and PREADY, PSLVERR (tied)
	always_ff @(posedge CLOCK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			s_r <= '0;
			s_r.ctrl <= mopm_pkg::CTRL_RESET;
			s_r.nl <= 1'b1;
			s_r.td <= 1'b1;
			s_r.ng <= 1'b1;
		end
		else
			s_r <= s_nxt;
	end

	assign PRDATA = s_r.prdata;
	assign MOTOR_OUT_A = s_r.mo_a;
	assign MOTOR_OUT_B = s_r.mo_b;
	assign LED = s_r.led;
	assign NO_LOAD_PIN = s_r.nl;
	assign NO_LOAD_PIN_OE = s_r.nl_oe;
	assign TAMPER_PIN = s_r.td;
	assign TAMPER_PIN_OE = s_r.td_oe;
	assign NEGATIVE_POWER_INDICATOR = s_r.ng;
	assign NEGATIVE_POWER_INDICATOR_OE = s_r.ng_oe;
	// level interrupt while any enabled sticky bit is set
	assign IRQ = |(s_r.ist & s_r.ien);
endmodule

// File: verification/mopm_checker.sv
/* port checker for the pin mux; shadows the mode
   field from APB writes, needs only top ports */
`timescale 1ns/10ps
module mopm_checker (
	input wire logic CLOCK,
	input wire logic SYS_RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic CUR_BITSTREAM,
	input wire logic VOLT_BITSTREAM,
	input wire logic STEPPER_PHASE_A,
	input wire logic STEPPER_PHASE_B,
	input wire logic INDICATOR_ENABLE_SELECT,
	input wire logic SPI_DATA_OE,
	input wire logic MOTOR_OUT_A,
	input wire logic MOTOR_OUT_B,
	input wire logic LED,
	input wire logic NO_LOAD_PIN_OE,
	input wire logic TAMPER_PIN_OE,
	input wire logic NEGATIVE_POWER_INDICATOR_OE,
	input wire logic IRQ
);
	logic [1:0] mode_r;
	logic wr;
	default clocking dc @(posedge CLOCK);
	endclocking
	default disable iff (SYS_RST);
	// write as the slave takes it
	assign wr = PSEL & PENABLE & PWRITE;
	// mode shadow, same edge as the design register
	always_ff @(posedge CLOCK or posedge SYS_RST)
		if (SYS_RST)
			mode_r <= 2'h0;
		else if (wr && PADDR == mopm_pkg::OFS_CTRL)
			mode_r <= PWDATA[1:0];
	AST_STEP: assert property ($past(mode_r[1]) |->
		{MOTOR_OUT_B, MOTOR_OUT_A} ==
		$past({STEPPER_PHASE_B, STEPPER_PHASE_A}))
		else $error("motor pins miss stepper phases");
	AST_DS: assert property ($past(mode_r) == 2'h1 |->
		{MOTOR_OUT_B, MOTOR_OUT_A} ==
		$past({CUR_BITSTREAM, VOLT_BITSTREAM}))
		else $error("motor pins miss bitstreams");
	AST_OE_ON: assert property (
		$past(mode_r[1] & INDICATOR_ENABLE_SELECT) |->
		NO_LOAD_PIN_OE & TAMPER_PIN_OE & NEGATIVE_POWER_INDICATOR_OE)
		else $error("indicator pins not driven");
	AST_OE_OFF: assert property (
		!$past(mode_r[1] & INDICATOR_ENABLE_SELECT) |->
		!NO_LOAD_PIN_OE && !NEGATIVE_POWER_INDICATOR_OE)
		else $error("indicator pins driven while off");
	AST_SPI: assert property (!$past(mode_r[1]) |->
		TAMPER_PIN_OE == $past(SPI_DATA_OE))
		else $error("tamper pin not given to serial port");
	AST_PULSE: assert property ($rose(LED) &&
		$past(mode_r) == 2'h3 && $past(mode_r, 2) == 2'h3 |->
		(LED || $past(mode_r) != 2'h3) [*8])
		else $error("energy pulse too short");
	AST_MASK: assert property (wr && PWDATA == 32'h0 &&
		PADDR == mopm_pkg::OFS_IRQ_EN |=> !IRQ)
		else $error("interrupt not masked");
	AST_READY: assert property (PSEL |-> PREADY && !PSLVERR)
		else $error("slave stalled or flagged error");
	cover property ($rose(LED) && mode_r == 2'h3);
	cover property ($rose(IRQ));
	cover property (TAMPER_PIN_OE && mode_r[1]);
endmodule

bind mopm_top mopm_checker chk (.*);

// File: verification/mopm_partner.sv
/* stepper driver and pulse counter beside the mux;
   runs on the bench clock and reset */
`timescale 1ns/10ps
module mopm_partner (
	input wire logic clock,
	input wire logic rst,
	input wire logic led,
	input wire logic ind_en,
	output logic phase_a,
	output logic phase_b,
	output logic ind_en_sel,
	output int led_count
);
	logic [1:0] step_r;
	logic led_r;
	// gray steps, one phase moves at a time
	assign phase_a = step_r[1];
	assign phase_b = step_r[1] ^ step_r[0];
	assign ind_en_sel = ind_en;
	// step every cycle, count led rises
	always_ff @(posedge clock or posedge rst)
		if (rst)
		begin
			step_r <= 2'h0;
			led_r <= 1'b0;
			led_count <= 0;
		end
		else
		begin
			step_r <= step_r + 2'h1;
			led_r <= led;
			led_count <= led_count + int'(led && !led_r);
		end
endmodule

// File: verification/testbench.sv
/* self-checking bench for the pin mux: APB master,
   xorshift stimulus, partner for stepper and enable */
`timescale 1ns/10ps
module testbench;
	logic CLOCK, SYS_RST, PSEL, PENABLE, PWRITE, VOLT_VALID, IRQ, LED;
	logic [7:0] PADDR;
	logic [31:0] PWDATA, PRDATA, rd, seed;
	logic [15:0] VOLT_SAMPLE, ACT_POWER, REACT_POWER, APP_POWER;
	logic PREADY, PSLVERR, CUR_BITSTREAM, VOLT_BITSTREAM, SPI_DATA_OUT;
	logic SPI_DATA_OE, STEPPER_PHASE_A, STEPPER_PHASE_B, MOTOR_OUT_A;
	logic MOTOR_OUT_B, INDICATOR_ENABLE_SELECT, NO_LOAD_PIN, TAMPER_PIN;
	logic NO_LOAD_PIN_OE, TAMPER_PIN_OE, NEGATIVE_POWER_INDICATOR, ind_en;
	logic NEGATIVE_POWER_INDICATOR_OE;
	logic [5:0] side;
	logic [3:0] r;
	logic [1:0] ph;
	logic [4:0] ctl [6] = '{5'h03, 5'h07, 5'h02, 5'h04, 5'h0C, 5'h14};
	int fail_count, comparisons, led_count, c0, e;
	mopm_top dut (.*);
	mopm_partner partner (.clock(CLOCK), .rst(SYS_RST), .led(LED),
		.ind_en(ind_en), .phase_a(STEPPER_PHASE_A),
		.phase_b(STEPPER_PHASE_B), .ind_en_sel(INDICATOR_ENABLE_SELECT),
		.led_count(led_count));
	// 100 MHz
	initial
	begin
		CLOCK = 1'b0;
		forever #5 CLOCK = ~CLOCK;
	end
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	function automatic logic [31:0] xs(logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	// pins as seen: motors, led, enables, driven levels
	function automatic logic [8:0] exp_pins(logic [2:0] m, logic [5:0] s,
		logic [3:0] r, logic [1:0] ph);
		logic en;
		logic [2:0] mot;
		en = m[1] & m[2];
		mot = m[1] ? {ph, 1'b0} : m[0] ? {r[3:2], s[1]} : {s[2], 2'h0};
		return {mot, en, en | (!m[1] & r[0]), en, en & !s[4],
			en ? !s[3] : (!m[1] & r[0] & r[1]), en & !s[5]};
	endfunction
	// led rises in 1024 cycles; fast mode period is K_FAST
	function automatic int exp_cnt(logic [4:0] c);
		int p;
		p = 256 << c[4:3];
		if (c[1:0] == 2'h2)
			return 1024 * p / mopm_pkg::K_FAST;
		return 1024 * p / (c[2] ? mopm_pkg::K_HIGH : mopm_pkg::K_LOW);
	endfunction
	// one transfer; entered and left just after a rising edge
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		int n;
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLOCK);
		PENABLE <= 1'b1;
		n = 0;
		do
		begin
			@(posedge CLOCK);
			n++;
		end
		while (PREADY !== 1'b1 && n < 50);
		rd = PRDATA;
		if (n >= 50)
		begin
			fail_count++;
			report_and_stop();
		end
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge CLOCK);
	endtask
	task automatic rdc(logic [7:0] a, logic [31:0] e);
		apb(1'b0, a, 32'h0);
		check($sformatf("reg %h", a), rd, e);
	endtask
	task automatic sample(logic [15:0] v, logic z);
		VOLT_SAMPLE <= v;
		VOLT_VALID <= 1'b1;
		@(posedge CLOCK);
		VOLT_VALID <= 1'b0;
		// mode-0 motor pin shows the crossing one edge after the flag
		repeat (2) @(negedge CLOCK);
		check("zero cross", MOTOR_OUT_A, z);
		repeat (2) @(posedge CLOCK);
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// main sequence
	initial
	begin
		{PSEL, PENABLE, PWRITE, VOLT_VALID, CUR_BITSTREAM} = '0;
		{VOLT_BITSTREAM, SPI_DATA_OUT, SPI_DATA_OE, ind_en} = '0;
		{PADDR, PWDATA, VOLT_SAMPLE, ACT_POWER, REACT_POWER, APP_POWER} = '0;
		{seed, fail_count, comparisons, SYS_RST} = {32'h2D, 64'h0, 1'b1};
		repeat (10) @(posedge CLOCK);
		SYS_RST <= 1'b0;
		@(posedge CLOCK);
		rdc(mopm_pkg::OFS_CTRL, mopm_pkg::CTRL_RESET);
		rdc(8'h20, 32'h0);
		// every mode, indications off then on
		for (int m = 0; m < 8; m++)
		begin
			ind_en <= m[2];
			seed = xs(seed);
			side = seed[5:0];
			apb(1'b1, mopm_pkg::OFS_CTRL, 32'(m % 4));
			apb(1'b1, mopm_pkg::OFS_SIDE, {26'h0, side});
			repeat (12)
			begin
				seed = xs(seed);
				r = seed[3:0];
				{CUR_BITSTREAM, VOLT_BITSTREAM, SPI_DATA_OUT, SPI_DATA_OE} <= r;
				@(negedge CLOCK);
				ph = {STEPPER_PHASE_B, STEPPER_PHASE_A};
				@(negedge CLOCK);
				check("pins", {MOTOR_OUT_B, MOTOR_OUT_A, LED, NO_LOAD_PIN_OE,
					TAMPER_PIN_OE, NEGATIVE_POWER_INDICATOR_OE,
					NO_LOAD_PIN & NO_LOAD_PIN_OE, TAMPER_PIN & TAMPER_PIN_OE,
					NEGATIVE_POWER_INDICATOR & NEGATIVE_POWER_INDICATOR_OE},
					exp_pins(3'(m), side, r,
					ph));
				@(posedge CLOCK);
			end
		end
		$display("mux test done");
		// samples across both thresholds and zero, mode 0 shows crossings
		apb(1'b1, mopm_pkg::OFS_CTRL, 32'h0);
		apb(1'b1, mopm_pkg::OFS_SIDE, 32'h1);
		sample(16'h00C8, 1'b0);
		apb(1'b1, mopm_pkg::OFS_IRQ_CLR, 32'h1F);
		sample(16'h0032, 1'b0);
		rdc(mopm_pkg::OFS_STATUS, 32'h4);
		sample(16'h0064, 1'b0);
		rdc(mopm_pkg::OFS_STATUS, 32'h4);
		sample(16'hFF38, 1'b1);
		rdc(mopm_pkg::OFS_STATUS, 32'h0);
		rdc(mopm_pkg::OFS_IRQ_STAT, 32'h14);
		rdc(mopm_pkg::OFS_VOLTAGE, 32'hFF38);
		sample(16'h012C, 1'b1);
		rdc(mopm_pkg::OFS_VOLTAGE, 32'h1012C);
		apb(1'b1, mopm_pkg::OFS_SIDE, 32'h0);
		rdc(mopm_pkg::OFS_STATUS, 32'h4);
		$display("voltage test done");
		// raise, mask, clear
		apb(1'b1, mopm_pkg::OFS_IRQ_EN, 32'h10);
		check("irq", IRQ, 1'b1);
		apb(1'b1, mopm_pkg::OFS_IRQ_EN, 32'h0);
		check("irq", IRQ, 1'b0);
		apb(1'b1, mopm_pkg::OFS_IRQ_EN, 32'h10);
		apb(1'b1, mopm_pkg::OFS_IRQ_CLR, 32'h10);
		check("irq", IRQ, 1'b0);
		rdc(mopm_pkg::OFS_IRQ_STAT, 32'h4);
		apb(1'b1, mopm_pkg::OFS_SIDE, 32'h39);
		apb(1'b0, mopm_pkg::OFS_STATUS, 32'h0);
		check("status", rd & 32'h1B, 32'hB);
		$display("flag test done");
		// pulse rates per mode, constant and source
		{ACT_POWER, REACT_POWER, APP_POWER} <= 48'h0100_0200_0400;
		foreach (ctl[i])
		begin
			apb(1'b1, mopm_pkg::OFS_CTRL, {27'h0, ctl[i]});
			repeat (20) @(posedge CLOCK);
			c0 = led_count;
			repeat (1024) @(posedge CLOCK);
			c0 = led_count - c0;
			e = exp_cnt(ctl[i]);
			// one pulse either way allowed for the window phase
			e = (c0 >= e - 1 && c0 <= e + 1) ? c0 : e;
			check("pulses", c0, e);
		end
		$display("energy test done");
		report_and_stop();
	end
endmodule
